// file: design/pefg_regs.sv
// event-flag register, interrupt mask and general configuration register bank
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pefg_regs
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   // register port
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [15:0] reg_rdata,
   // event pulses from the phy core
   input  wire logic        negotiation_error_event,
   input  wire logic        rate_change_event,
   input  wire logic        duplex_change_event,
   input  wire logic        page_received_event,
   input  wire logic        negotiation_done_event,
   input  wire logic        link_change_event,
   input  wire logic        spurious_carrier_event,
   input  wire logic        converter_queue_fault_event,
   input  wire logic        crossover_change_event,
   input  wire logic        downshift_event,
   input  wire logic        sleep_change_event,
   input  wire logic        jabber_event,
   // live status levels from the phy core
   input  wire logic        energy_efficient_error_flag,
   input  wire logic        wake_packet_flag,
   input  wire logic        mac_buffer_fault_flag,
   input  wire logic        polarity_change_flag,
   // hardware clear of the detection enable
   input  wire logic        powered_device_detect_clear,
   // interrupt pin level
   output var  logic        irq_pin,
   // configuration outputs
   output var  logic        powered_device_detect_enable,
   output var  logic        serial_mac_tx_error_disable,
   output var  logic        serial_mac_soft_reset,
   output var  logic [1:0]  downshift_attempt_count,
   output var  logic [3:0]  downshift_attempt_limit,
   output var  logic        downshift_enable,
   output var  logic        downshift_enhanced_enable,
   output var  logic        serial_mac_negotiation_enable,
   output var  logic        downshift_to_ten_enable,
   output var  logic [1:0]  gmii_tx_clock_select,
   output var  logic        gmii_tx_clock_enable,
   output var  logic        collision_full_duplex_enable,
   output var  logic        legacy_scrambler_auto_enable,
   output var  logic        master_semi_cross_enable,
   output var  logic        slave_semi_cross_enable
);

   // attempt count field to number of failed attempts
   function automatic logic [3:0] attempts_of(input logic [1:0] code);
      attempts_of = 4'h1 << code;
   endfunction

   logic [15:0] flags_reg;
   logic [15:0] flags_next;
   logic [15:0] mask_reg;
   logic [15:0] mask_next;
   logic [15:0] cfg_reg;
   logic [15:0] cfg_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        pulse_reg;
   logic        irq_reg;
   logic        irq_next;
   logic [3:0]  limit_reg;
   logic        clk_en_reg;
   logic        clk_on_reg;

   // address decode
   wire         sel_mask  = (reg_addr == pefg_pkg::OFS_MASK);
   wire         sel_flags = (reg_addr == pefg_pkg::OFS_FLAGS);
   wire         sel_cfg   = (reg_addr == pefg_pkg::OFS_CFG);
   wire         wr_mask   = reg_wr & sel_mask;
   wire         wr_cfg    = reg_wr & sel_cfg;
   wire         rd_clear  = reg_rd & sel_flags;

   // incoming events gathered into register positions
   wire  [15:0] event_vec;
   assign event_vec[pefg_pkg::F_NEG_ERR]   = negotiation_error_event;
   assign event_vec[pefg_pkg::F_RATE]      = rate_change_event;
   assign event_vec[pefg_pkg::F_DUPLEX]    = duplex_change_event;
   assign event_vec[pefg_pkg::F_PAGE]      = page_received_event;
   assign event_vec[pefg_pkg::F_NEG_DONE]  = negotiation_done_event;
   assign event_vec[pefg_pkg::F_LINK]      = link_change_event;
   assign event_vec[pefg_pkg::F_EEE]       = 1'b0;
   assign event_vec[pefg_pkg::F_CARRIER]   = spurious_carrier_event;
   assign event_vec[pefg_pkg::F_CONVERTER] = converter_queue_fault_event;
   assign event_vec[pefg_pkg::F_CROSSOVER] = crossover_change_event;
   assign event_vec[pefg_pkg::F_DOWNSHIFT] = downshift_event;
   assign event_vec[pefg_pkg::F_SLEEP]     = sleep_change_event;
   assign event_vec[pefg_pkg::F_WAKE]      = 1'b0;
   assign event_vec[pefg_pkg::F_MAC_BUF]   = 1'b0;
   assign event_vec[pefg_pkg::F_POLARITY]  = 1'b0;
   assign event_vec[pefg_pkg::F_JABBER]    = jabber_event;

   // live levels; the buffer fault source is known to misreport
   wire  [15:0] level_vec;
   assign level_vec = {6'h00,
                       energy_efficient_error_flag,
                       5'h00,
                       wake_packet_flag,
                       mac_buffer_fault_flag,
                       polarity_change_flag,
                       1'b0};

   // set wins over the read clear so no event is lost; mask plays no part
   assign flags_next = ((flags_reg & ~{16{rd_clear}}) | event_vec)
                       & pefg_pkg::LATCH_BITS;

   wire  [15:0] flags_view = (flags_reg & pefg_pkg::LATCH_BITS) | level_vec;

   assign mask_next = wr_mask ? reg_wdata : mask_reg;

   // config write; detection enable may be dropped by hardware unless written
   wire         pd_next = wr_cfg ? reg_wdata[pefg_pkg::C_PD_EN] :
                          (cfg_reg[pefg_pkg::C_PD_EN] & ~powered_device_detect_clear);
   wire         soft_req = wr_cfg & reg_wdata[pefg_pkg::C_SOFT_RST];
   assign cfg_next = {pd_next,
                      wr_cfg ? reg_wdata[14:13] : cfg_reg[14:13],
                      1'b0,
                      wr_cfg ? reg_wdata[11:0] : cfg_reg[11:0]};

   // unmapped addresses read as zero
   assign rdata_next = sel_mask  ? mask_reg :
                       sel_flags ? flags_view :
                       sel_cfg   ? {cfg_reg[15:13], pulse_reg, cfg_reg[11:0]} :
                       16'h0000;

   // pin follows enabled flags, inverted when polarity bit asks for active low
   wire         irq_active = |(flags_view & mask_reg);
   assign irq_next = irq_active ^ cfg_reg[pefg_pkg::C_IRQ_POL];

   // latched flags and mask
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flags_reg <= pefg_pkg::FLAGS_RESET;
         mask_reg  <= pefg_pkg::MASK_RESET;
      end
      else if (clk_en)
      begin
         flags_reg <= flags_next;
         mask_reg  <= mask_next;
      end
   end

   // configuration and soft reset pulse
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_reg   <= pefg_pkg::CFG_RESET;
         pulse_reg <= 1'b0;
         limit_reg <= 4'h4;
         clk_on_reg <= ~pefg_pkg::CFG_RESET[pefg_pkg::C_CLK_HI];
      end
      else if (clk_en)
      begin
         cfg_reg   <= cfg_next;
         pulse_reg <= soft_req;
         limit_reg <= attempts_of(cfg_next[pefg_pkg::C_ATT_HI:pefg_pkg::C_ATT_LO]);
         // codes 2 and 3 both stop the clock, so only the high bit matters
         clk_on_reg <= ~cfg_next[pefg_pkg::C_CLK_HI];
      end
   end

   // read data stands one cycle after the strobe
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_reg <= 16'h0000;
         // idle pin level, so no false interrupt shows while in reset
         irq_reg   <= pefg_pkg::CFG_RESET[pefg_pkg::C_IRQ_POL];
      end
      else if (clk_en)
      begin
         rdata_reg <= reg_rd ? rdata_next : 16'h0000;
         irq_reg   <= irq_next;
      end
   end

   // helper for assertions: was the clock enabled last cycle
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         clk_en_reg <= 1'b0;
      else
         clk_en_reg <= clk_en;
   end

   assign reg_rdata                     = rdata_reg;
   assign irq_pin                       = irq_reg;
   assign powered_device_detect_enable  = cfg_reg[pefg_pkg::C_PD_EN];
   assign serial_mac_tx_error_disable   = cfg_reg[pefg_pkg::C_TXERR_DIS];
   assign serial_mac_soft_reset         = pulse_reg;
   assign downshift_attempt_count       = cfg_reg[pefg_pkg::C_ATT_HI:pefg_pkg::C_ATT_LO];
   assign downshift_attempt_limit       = limit_reg;
   assign downshift_enable              = cfg_reg[pefg_pkg::C_DS_EN];
   assign downshift_enhanced_enable     = cfg_reg[pefg_pkg::C_DS_ENH];
   assign serial_mac_negotiation_enable = cfg_reg[pefg_pkg::C_SM_NEG];
   assign downshift_to_ten_enable       = cfg_reg[pefg_pkg::C_DS_TEN];
   assign gmii_tx_clock_select          = cfg_reg[pefg_pkg::C_CLK_HI:pefg_pkg::C_CLK_LO];
   assign gmii_tx_clock_enable          = clk_on_reg;
   assign collision_full_duplex_enable  = cfg_reg[pefg_pkg::C_COL_FD];
   assign legacy_scrambler_auto_enable  = cfg_reg[pefg_pkg::C_LEGACY];
   assign master_semi_cross_enable      = cfg_reg[pefg_pkg::C_SEMI_MST];
   assign slave_semi_cross_enable       = cfg_reg[pefg_pkg::C_SEMI_SLV];

   // an event sets its flag even when masked
   event_sets_flag_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && jabber_event && mask_reg[pefg_pkg::F_JABBER] == 1'b0
      |=> flags_reg[pefg_pkg::F_JABBER])
      else $error("jabber event did not set its flag");

   mask_free_set_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && (event_vec & pefg_pkg::LATCH_BITS) != 16'h0000
      |=> (flags_reg & $past(event_vec)) == $past(event_vec & pefg_pkg::LATCH_BITS))
      else $error("event lost while mask clear");

   // a latched flag holds until a clearing read
   latch_hold_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && flags_reg[pefg_pkg::F_LINK] && !rd_clear
      |=> flags_reg[pefg_pkg::F_LINK])
      else $error("link change flag dropped without a read");

   read_clears_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && rd_clear && event_vec == 16'h0000
      ##1 clk_en_reg |-> flags_reg == 16'h0000 && reg_rdata == $past(flags_view))
      else $error("read did not return and clear flags");

   set_beats_clear_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && rd_clear && converter_queue_fault_event
      |=> flags_reg[pefg_pkg::F_CONVERTER] ##1 flags_reg[pefg_pkg::F_CONVERTER] || !clk_en_reg
          || $past(rd_clear))
      else $error("converter fault lost under clearing read");

   level_bits_live_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && rd_clear
      |=> (reg_rdata & pefg_pkg::LEVEL_BITS) == $past(level_vec))
      else $error("status levels misread");

   soft_pulse_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && soft_req ##1 clk_en && !soft_req
      |-> serial_mac_soft_reset ##1 !serial_mac_soft_reset)
      else $error("soft reset not a single pulse");

   pd_hw_clear_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && powered_device_detect_clear && !wr_cfg
      |=> !powered_device_detect_enable)
      else $error("detection enable not cleared by hardware");

   irq_pin_level_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && clk_en_reg
      |=> irq_pin == ($past(|(flags_view & mask_reg)) ^ $past(cfg_reg[pefg_pkg::C_IRQ_POL])))
      else $error("interrupt pin level wrong");

   attempt_limit_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      clk_en && wr_cfg && reg_wdata[11:10] == 2'h3
      |=> downshift_attempt_limit == 4'h8)
      else $error("attempt limit decode wrong");

   clock_off_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      gmii_tx_clock_select == 2'h2 |-> !gmii_tx_clock_enable)
      else $error("transmit clock not stopped");

endmodule
`default_nettype wire

// file: design/pefg_pkg.sv
// constants for the event-flag, interrupt mask and general configuration registers
package pefg_pkg;
   localparam int          ADDR_W       = 5;
   localparam int          DATA_W       = 16;
   localparam logic [4:0]  OFS_MASK     = 5'h12;
   localparam logic [4:0]  OFS_FLAGS    = 5'h13;
   localparam logic [4:0]  OFS_CFG      = 5'h14;
   localparam logic [15:0] MASK_RESET   = 16'h0000;
   localparam logic [15:0] FLAGS_RESET  = 16'h0000;
   localparam logic [15:0] CFG_RESET    = 16'h29C7;
   // bits that latch high and clear on read
   localparam logic [15:0] LATCH_BITS   = 16'hFDF1;
   // bits that show a live level
   localparam logic [15:0] LEVEL_BITS   = 16'h020E;
   // flag positions
   localparam int          F_NEG_ERR    = 15;
   localparam int          F_RATE       = 14;
   localparam int          F_DUPLEX     = 13;
   localparam int          F_PAGE       = 12;
   localparam int          F_NEG_DONE   = 11;
   localparam int          F_LINK       = 10;
   localparam int          F_EEE        = 9;
   localparam int          F_CARRIER    = 8;
   localparam int          F_CONVERTER  = 7;
   localparam int          F_CROSSOVER  = 6;
   localparam int          F_DOWNSHIFT  = 5;
   localparam int          F_SLEEP      = 4;
   localparam int          F_WAKE       = 3;
   localparam int          F_MAC_BUF    = 2;
   localparam int          F_POLARITY   = 1;
   localparam int          F_JABBER     = 0;
   // configuration field positions
   localparam int          C_PD_EN      = 15;
   localparam int          C_TXERR_DIS  = 14;
   localparam int          C_IRQ_POL    = 13;
   localparam int          C_SOFT_RST   = 12;
   localparam int          C_ATT_HI     = 11;
   localparam int          C_ATT_LO     = 10;
   localparam int          C_DS_EN      = 9;
   localparam int          C_DS_ENH     = 8;
   localparam int          C_SM_NEG     = 7;
   localparam int          C_DS_TEN     = 6;
   localparam int          C_CLK_HI     = 5;
   localparam int          C_CLK_LO     = 4;
   localparam int          C_COL_FD     = 3;
   localparam int          C_LEGACY     = 2;
   localparam int          C_SEMI_MST   = 1;
   localparam int          C_SEMI_SLV   = 0;
   localparam logic [1:0]  CLK_SEL_SLOW = 2'h0;
   localparam logic [1:0]  CLK_SEL_FAST = 2'h1;
endpackage

// file: design/pefg_pkg_end.sv
// intentionally small: no further definitions

// file: tb/pefg_regs_test.sv
// self-checking bench for the event-flag and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module pefg_regs_test;
   // compare a design value with its expectation, count, report at once
   `define CHK(what, exp, got) \
      begin \
         num_checks++; \
         if ((got) !== (exp)) \
         begin \
            mismatches++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
         end \
      end
   logic        clk;
   logic        arst_n;
   logic        clk_en;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [11:0] ev;
   logic [3:0]  lv;
   logic        pd_clear;
   logic        irq_pin;
   logic        pd_en, tx_dis, soft_rst, ds_en, ds_enh, sm_neg, ds_ten;
   logic        clk_on, col_fd, legacy, semi_m, semi_s;
   logic [1:0]  att, clk_sel;
   logic [3:0]  att_lim;
   logic [15:0] w;
   int          mismatches;
   int          num_checks;
   // flag position of each event input, ev[i] drives the event at POS[i]
   localparam int POS [12] = '{15, 14, 13, 12, 11, 10, 8, 7, 6, 5, 4, 0};
   // configuration outputs in register order, bit 13 and 12 left out
   wire [13:0]  cfg_view = {pd_en, tx_dis, att, ds_en, ds_enh, sm_neg, ds_ten, clk_sel,
                            col_fd, legacy, semi_m, semi_s};

   pefg_regs dut_u (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .negotiation_error_event(ev[0]), .rate_change_event(ev[1]), .duplex_change_event(ev[2]),
      .page_received_event(ev[3]), .negotiation_done_event(ev[4]), .link_change_event(ev[5]),
      .spurious_carrier_event(ev[6]), .converter_queue_fault_event(ev[7]),
      .crossover_change_event(ev[8]), .downshift_event(ev[9]), .sleep_change_event(ev[10]),
      .jabber_event(ev[11]), .energy_efficient_error_flag(lv[3]), .wake_packet_flag(lv[2]),
      .mac_buffer_fault_flag(lv[1]), .polarity_change_flag(lv[0]),
      .powered_device_detect_clear(pd_clear), .irq_pin(irq_pin),
      .powered_device_detect_enable(pd_en), .serial_mac_tx_error_disable(tx_dis),
      .serial_mac_soft_reset(soft_rst), .downshift_attempt_count(att),
      .downshift_attempt_limit(att_lim), .downshift_enable(ds_en),
      .downshift_enhanced_enable(ds_enh), .serial_mac_negotiation_enable(sm_neg),
      .downshift_to_ten_enable(ds_ten), .gmii_tx_clock_select(clk_sel),
      .gmii_tx_clock_enable(clk_on), .collision_full_duplex_enable(col_fd),
      .legacy_scrambler_auto_enable(legacy), .master_semi_cross_enable(semi_m),
      .slave_semi_cross_enable(semi_s));

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // one-cycle write, strobe dropped at the edge that takes it
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // one-cycle read, data looked at only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(what, exp, reg_rdata)
   endtask

   // one-cycle pulse on a set of event inputs
   task automatic pulse(input logic [11:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 12'h000;
      #1;
   endtask

   task automatic test_done();
      if (mismatches == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // hang guard, the tests need well under a thousand cycles
   initial
   begin
      #200000;
      mismatches++;
      test_done();
   end

   initial
   begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ev = 12'h000;
      lv = 4'h0;
      pd_clear = 1'b0;
      mismatches = 0;
      num_checks = 0;
      repeat (6) @(posedge clk);
      `CHK("irq in reset", 1'b1, irq_pin)
      `CHK("tx clock in reset", 1'b1, clk_on)
      arst_n <= 1'b1;
      rd(5'h12, 16'h0000, "mask reset");
      rd(5'h13, 16'h0000, "flags reset");
      rd(5'h14, 16'h29C7, "config reset");
      rd(5'h1F, 16'h0000, "unmapped read");
      @(posedge clk);
      #1;
      `CHK("read data idle", 16'h0000, reg_rdata)
      `CHK("config outputs reset", 14'h09C7, cfg_view)
      `CHK("attempt limit reset", 4'h4, att_lim)
      `CHK("irq idle", 1'b1, irq_pin)
      // every latched flag alone, mask all clear
      for (int i = 0; i < 12; i++)
      begin
         pulse(12'h001 << i);
         rd(5'h13, 16'h0001 << POS[i], "flag latched");
         `CHK("irq masked", 1'b1, irq_pin)
         rd(5'h13, 16'h0000, "flag cleared");
      end
      pulse(12'hFFF);
      rd(5'h13, 16'hFDF1, "all flags latched");
      // live levels are neither latched nor cleared
      lv <= 4'hF;
      rd(5'h13, 16'h020E, "levels shown");
      rd(5'h13, 16'h020E, "levels kept");
      lv <= 4'h5;
      rd(5'h13, 16'h000A, "levels follow");
      lv <= 4'h0;
      wr(5'h13, 16'hFFFF);
      rd(5'h13, 16'h0000, "flags not writable");
      // event arriving with the clearing read survives it
      pulse(12'h002);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= 5'h13;
      ev       <= 12'h880;
      @(posedge clk);
      reg_rd <= 1'b0;
      ev     <= 12'h000;
      #1;
      `CHK("read before clear", 16'h4000, reg_rdata)
      rd(5'h13, 16'h0081, "event during clear");
      // interrupt enable and pin polarity
      wr(5'h12, 16'h0001);
      rd(5'h12, 16'h0001, "mask readback");
      pulse(12'h001);
      @(posedge clk);
      #1;
      `CHK("irq other event", 1'b1, irq_pin)
      pulse(12'h800);
      @(posedge clk);
      #1;
      `CHK("irq active low", 1'b0, irq_pin)
      wr(5'h14, 16'h09C7);
      @(posedge clk);
      #1;
      `CHK("irq active high", 1'b1, irq_pin)
      rd(5'h13, 16'h8001, "flags under irq");
      @(posedge clk);
      #1;
      `CHK("irq after clear", 1'b0, irq_pin)
      // whole-register writes and read-back, soft reset bit reads zero
      for (int k = 0; k < 2; k++)
      begin
         w = k ? 16'hEFFF : 16'h0000;
         wr(5'h14, w);
         `CHK("config outputs", {w[15:14], w[11:0]}, cfg_view)
         `CHK("no soft reset", 1'b0, soft_rst)
         rd(5'h14, w, "config readback");
      end
      wr(5'h14, 16'h39C7);
      `CHK("soft reset pulse", 1'b1, soft_rst)
      @(posedge clk);
      #1;
      `CHK("soft reset ends", 1'b0, soft_rst)
      rd(5'h14, 16'h29C7, "soft reset self clears");
      // attempt count decode and transmit clock codes
      for (int k = 0; k < 4; k++)
      begin
         w = (16'h29C7 & 16'hF3CF) | (16'(k) << 10) | (16'(k) << 4);
         wr(5'h14, w);
         `CHK("attempt limit", 4'h1 << k, att_lim)
         `CHK("tx clock enable", (k < 2), clk_on)
      end
      // hardware clear of the detection enable
      wr(5'h14, 16'h8000);
      `CHK("detect enabled", 1'b1, pd_en)
      @(posedge clk);
      pd_clear <= 1'b1;
      @(posedge clk);
      pd_clear <= 1'b0;
      rd(5'h14, 16'h0000, "detect cleared");
      `CHK("detect output cleared", 1'b0, pd_en)
      // a write while the clock enable is low is ignored
      @(posedge clk);
      clk_en    <= 1'b0;
      reg_wr    <= 1'b1;
      reg_addr  <= 5'h14;
      reg_wdata <= 16'hFFFF;
      @(posedge clk);
      reg_wr <= 1'b0;
      clk_en <= 1'b1;
      rd(5'h14, 16'h0000, "gated write ignored");
      test_done();
   end
   `undef CHK
endmodule
`default_nettype wire
